//--- hw/opmc_defines.svh
// opmc constants: timing, sizes and test-mode bit map
`ifndef OPMC_DEFINES_SVH
`define OPMC_DEFINES_SVH
`define OPMC_CLK_MHZ 250
`define OPMC_SCLK_MHZ 10
`define OPMC_RCLK_MHZ 40
`define OPMC_SCLK_DIV (`OPMC_CLK_MHZ / `OPMC_SCLK_MHZ)
`define OPMC_RCLK_DIV (`OPMC_CLK_MHZ / `OPMC_RCLK_MHZ)
`define OPMC_PROC_TIME_US 88
`define OPMC_DEF_SAMPLES (`OPMC_PROC_TIME_US * `OPMC_SCLK_MHZ)
`define OPMC_DRIVE_DELAY 3
`define OPMC_NUM_CH 16
`define OPMC_LAST_CH 4'hf
`define OPMC_ADC_W 10
`define OPMC_BUS_W 40
`define OPMC_MEM_DEPTH 1024
`define OPMC_FIFO_DEPTH 16
`define OPMC_SCAN_LEN 13915
`define OPMC_GRP1_BASE 4
`define OPMC_GRP2_BASE 8
`define OPMC_GRP3_BASE 12
`define OPMC_FIRST_HI 39
`define OPMC_FIRST_LO 30
`define OPMC_THIRD_HI 29
`define OPMC_THIRD_LO 20
`define OPMC_SECOND_HI 9
`define OPMC_SECOND_LO 0
`endif

//--- hw/opmc_pkg.sv
// opmc types: phases, readout steps and carried words
package opmc_pkg;
  typedef enum logic [1:0] {PH_STANDBY, PH_CONFIG, PH_PROCESS, PH_READOUT} opmc_phase_e;
  typedef enum logic [2:0] {RD_ACK, RD_GAP, RD_DRIVE, RD_XFER, RD_END} opmc_step_e;
  typedef struct packed {
    logic valid;
    logic all;
    logic broadcast;
    logic [3:0] chan;
  } opmc_cmd_s;
  typedef struct packed {
    logic [5:0] pad;
    logic [3:0] chan;
    logic [9:0] idx;
    logic [9:0] rsv;
    logic [9:0] sample;
  } opmc_word_s;
endpackage : opmc_pkg

//--- hw/opmc_top.sv
// opmc: operating-mode control, test bus mux, run phases and readout path
`timescale 1ns/100ps
`include "opmc_defines.svh"

module opmc_fifo #(
  parameter int W = 40,
  parameter int D = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] store [0:D-1];
  logic [AW:0] wp;
  logic [AW:0] rp;
  // extra pointer bit tells full from empty
  assign in_ready_o = !((wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]));
  assign out_valid_o = (wp != rp);
  assign out_data_o = store[rp[AW-1:0]];
  // write port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wp <= '0;
    else if (in_valid_i && in_ready_o)
    begin
      store[wp[AW-1:0]] <= in_data_i;
      wp <= wp + 1'b1;
    end
  end
  // read port
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rp <= '0;
    else if (out_valid_o && out_ready_i)
      rp <= rp + 1'b1;
  end
endmodule : opmc_fifo

module opmc_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // mode and test group select
  input wire logic mode_select_line_i,
  input wire logic group_select_low_i,
  input wire logic group_select_high_i,
  // converter outputs, channel n at bits 10n+9:10n
  input wire logic [159:0] adc_data_i,
  // run control
  input wire logic trigger_i,
  input wire logic config_access_i,
  input wire logic [9:0] samples_per_event_count_i,
  input wire logic [15:0] chan_enable_i,
  input wire opmc_pkg::opmc_cmd_s cmd_i,
  // baseline memory pattern source
  input wire logic pattern_mode_i,
  input wire logic bl_wr_i,
  input wire logic [9:0] bl_addr_i,
  input wire logic [9:0] bl_data_i,
  // bidirectional bus, split
  input wire logic bus_ready_i,
  output logic [39:0] bidirectional_bus_o,
  output logic bidirectional_bus_oe_o,
  output logic ack_o,
  output logic transfer_o,
  output logic data_strobe_o,
  output logic [1:0] phase_o,
  // scan chain
  input wire logic scan_enable_i,
  input wire logic scan_in_i,
  output logic scan_out_o
);
  import opmc_pkg::*;
  logic [4:0] sclk_cnt;
  logic [2:0] rclk_cnt;
  logic sclk_tick;
  logic rclk_tick;
  opmc_phase_e ph_a, ph_b, ph_c, phase, next_phase;
  opmc_step_e step;
  logic [1:0] gap_cnt;
  logic [9:0] smp_idx;
  logic [9:0] smp_target;
  logic [9:0] chan_len [0:15];
  logic [9:0] rd_sample [0:15];
  logic [9:0] bl_mem [0:`OPMC_MEM_DEPTH-1];
  logic [3:0] rd_ch;
  logic [9:0] rd_idx;
  logic rd_all;
  logic rd_done;
  logic resume;
  logic proc_done;
  logic push;
  logic fifo_ready;
  logic fifo_valid;
  logic pop;
  opmc_word_s push_word;
  opmc_word_s pop_word;
  logic [1:0] k;
  logic [`OPMC_SCAN_LEN-1:0] scan_chain;

  // clock enables; readout rate rounds to the faster integer divider
  assign sclk_tick = (sclk_cnt == 5'(`OPMC_SCLK_DIV - 1));
  assign rclk_tick = (rclk_cnt == 3'(`OPMC_RCLK_DIV - 1));
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || sclk_tick)
      sclk_cnt <= '0;
    else
      sclk_cnt <= sclk_cnt + 1'b1;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || rclk_tick)
      rclk_cnt <= '0;
    else
      rclk_cnt <= rclk_cnt + 1'b1;
  end

  // majority vote masks a single upset copy
  function automatic opmc_phase_e vote(opmc_phase_e a, opmc_phase_e b, opmc_phase_e c);
    vote = (a == b || a == c) ? a : b;
  endfunction : vote
  assign phase = vote(ph_a, ph_b, ph_c);

  // zero count falls back so an unconfigured chip still runs
  assign smp_target = (samples_per_event_count_i == '0) ?
    10'(`OPMC_DEF_SAMPLES) : samples_per_event_count_i;
  assign proc_done = sclk_tick && (smp_idx == smp_target - 1'b1);

  // phase sequencing
  always_comb
  begin
    next_phase = phase;
    if (!mode_select_line_i)
      next_phase = PH_STANDBY;
    else
    begin
      unique case (phase)
        PH_STANDBY:
          if (trigger_i)
            next_phase = PH_PROCESS;
          else if (cmd_i.valid && rclk_tick)
            next_phase = PH_READOUT;
          else if (config_access_i)
            next_phase = PH_CONFIG;
        PH_CONFIG:
          if (!config_access_i)
            next_phase = PH_STANDBY;
        PH_PROCESS:
          if (proc_done)
            next_phase = resume ? PH_READOUT : PH_STANDBY;
        PH_READOUT:
          if (trigger_i)
            next_phase = PH_PROCESS;
          else if (step == RD_END && rclk_tick)
            next_phase = PH_STANDBY;
      endcase
    end
  end
  // all three copies reload from the vote every cycle, so an upset heals
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      ph_a <= PH_STANDBY;
      ph_b <= PH_STANDBY;
      ph_c <= PH_STANDBY;
    end
    else
    begin
      ph_a <= next_phase;
      ph_b <= next_phase;
      ph_c <= next_phase;
    end
  end

  // suspend marker for a readout pre-empted by a trigger
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      resume <= 1'b0;
    else if (phase == PH_READOUT && next_phase == PH_PROCESS)
      resume <= 1'b1;
    else if (phase == PH_PROCESS && next_phase != PH_PROCESS)
      resume <= 1'b0;
  end

  // baseline pattern memory, written whenever bl_wr_i is high, in any phase
  always_ff @(posedge ref_clk_i)
  begin
    if (bl_wr_i)
      bl_mem[bl_addr_i] <= bl_data_i;
  end

  // sample counter of the processing phase
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || phase != PH_PROCESS)
      smp_idx <= '0;
    else if (sclk_tick)
      smp_idx <= smp_idx + 1'b1;
  end

  // per-channel data memory and stored event length
  for (genvar ch = 0; ch < `OPMC_NUM_CH; ch++)
  begin : g_chan
    logic [9:0] mem [0:`OPMC_MEM_DEPTH-1];
    logic [9:0] src;
    // pattern stands in for the converter to exercise the data path
    assign src = pattern_mode_i ? bl_mem[smp_idx] : adc_data_i[ch*10 +: 10];
    assign rd_sample[ch] = mem[rd_idx];
    always_ff @(posedge ref_clk_i)
    begin
      if (phase == PH_PROCESS && sclk_tick)
        mem[smp_idx] <= src;
    end
    // disabled channels get a zero stored length and are skipped on readout
    always_ff @(posedge ref_clk_i)
    begin
      if (rst_i)
        chan_len[ch] <= '0;
      else if (phase == PH_PROCESS && proc_done)
        chan_len[ch] <= chan_enable_i[ch] ? smp_target : '0;
    end
  end

  // readout step sequencer, paced by the readout clock enable
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      step <= RD_ACK;
      gap_cnt <= '0;
      ack_o <= 1'b0;
      transfer_o <= 1'b0;
      rd_all <= 1'b0;
    end
    else if (phase == PH_PROCESS && resume)
    begin
      transfer_o <= 1'b0;
      step <= RD_GAP;
      gap_cnt <= '0;
    end
    else if (rclk_tick)
    begin
      if (phase == PH_STANDBY && next_phase == PH_READOUT)
      begin
        ack_o <= !cmd_i.broadcast;
        rd_all <= cmd_i.all;
        step <= RD_ACK;
      end
      else if (phase == PH_READOUT)
      begin
        unique case (step)
          RD_ACK:
          begin
            ack_o <= 1'b0;
            gap_cnt <= '0;
            step <= RD_GAP;
          end
          RD_GAP:
          begin
            gap_cnt <= gap_cnt + 1'b1;
            if (gap_cnt == 2'(`OPMC_DRIVE_DELAY - 1))
              step <= RD_DRIVE;
          end
          RD_DRIVE:
          begin
            transfer_o <= 1'b1;
            step <= RD_XFER;
          end
          RD_XFER:
            if (rd_done && !fifo_valid)
            begin
              transfer_o <= 1'b0;
              step <= RD_END;
            end
          RD_END:
            step <= RD_ACK;
        endcase
      end
    end
  end

  // memory reader walks one channel or all of them
  assign push = (phase == PH_READOUT) && (step == RD_XFER) && !rd_done &&
                (rd_idx < chan_len[rd_ch]) && fifo_ready;
  assign push_word = '{pad: '0, chan: rd_ch, idx: rd_idx, rsv: '0, sample: rd_sample[rd_ch]};
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || (phase == PH_STANDBY && next_phase == PH_READOUT))
    begin
      rd_ch <= (rst_i || cmd_i.all) ? 4'h0 : cmd_i.chan;
      rd_idx <= '0;
      rd_done <= 1'b0;
    end
    else if (push)
      rd_idx <= rd_idx + 1'b1;
    else if (phase == PH_READOUT && step == RD_XFER && !rd_done &&
             rd_idx >= chan_len[rd_ch])
    begin
      if (rd_all && rd_ch != `OPMC_LAST_CH)
      begin
        rd_ch <= rd_ch + 1'b1;
        rd_idx <= '0;
      end
      else
        rd_done <= 1'b1;
    end
  end

  // output buffer; bus_ready_i stalls the drain and so the reader
  opmc_fifo #(.W(`OPMC_BUS_W), .D(`OPMC_FIFO_DEPTH)) u_fifo (
    .clk_i(ref_clk_i),
    .rst_i(rst_i),
    .in_valid_i(push),
    .in_ready_o(fifo_ready),
    .in_data_i(push_word),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(pop_word)
  );
  // no word leaves on the edge a trigger pre-empts the readout
  assign pop = rclk_tick && (phase == PH_READOUT) && (next_phase == PH_READOUT) &&
               transfer_o && bus_ready_i;

  // bus drive: test mux in test mode, readout words only in readout
  assign k = {group_select_high_i, group_select_low_i};
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      bidirectional_bus_o <= '0;
      bidirectional_bus_oe_o <= 1'b0;
      data_strobe_o <= 1'b0;
    end
    else if (!mode_select_line_i)
    begin
      data_strobe_o <= 1'b0;
      bidirectional_bus_oe_o <= 1'b1;
      bidirectional_bus_o <= '0;
      bidirectional_bus_o[`OPMC_FIRST_HI:`OPMC_FIRST_LO] <=
        adc_data_i[(`OPMC_GRP1_BASE + k)*10 +: 10];
      bidirectional_bus_o[`OPMC_THIRD_HI:`OPMC_THIRD_LO] <=
        adc_data_i[(`OPMC_GRP3_BASE + k)*10 +: 10];
      bidirectional_bus_o[`OPMC_SECOND_HI:`OPMC_SECOND_LO] <=
        adc_data_i[(`OPMC_GRP2_BASE + k)*10 +: 10];
    end
    else
    begin
      data_strobe_o <= pop && fifo_valid;
      if (pop && fifo_valid)
        bidirectional_bus_o <= pop_word;
      // master only between drive step and end of transfer; a pre-empting
      // trigger releases the bus on its own edge, not one cycle into processing
      if (phase != PH_READOUT || next_phase != PH_READOUT)
        bidirectional_bus_oe_o <= 1'b0;
      else if (rclk_tick && step == RD_GAP && gap_cnt == 2'(`OPMC_DRIVE_DELAY - 1))
        bidirectional_bus_oe_o <= 1'b1;
      else if (rclk_tick && step == RD_END)
        bidirectional_bus_oe_o <= 1'b0;
    end
  end

  // scan chain is a pure shift path; functional state is not frozen
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      scan_chain <= '0;
      scan_out_o <= 1'b0;
    end
    else if (scan_enable_i)
    begin
      scan_chain <= {scan_chain[`OPMC_SCAN_LEN-2:0], scan_in_i};
      scan_out_o <= scan_chain[`OPMC_SCAN_LEN-1];
    end
  end

  // observed phase
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      phase_o <= 2'h0;
    else
      phase_o <= next_phase;
  end
endmodule : opmc_top

//--- tb/opmc_top_properties.sv
// opmc checker: port-level bus map, handshake and phase assertions
`timescale 1ns/100ps
module opmc_props (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // controls
  input wire logic mode_select_line_i,
  input wire logic group_select_low_i,
  input wire logic group_select_high_i,
  input wire logic [159:0] adc_data_i,
  input wire logic trigger_i,
  input wire logic config_access_i,
  input wire logic bus_ready_i,
  // bus side
  input wire logic [39:0] bidirectional_bus_o,
  input wire logic bidirectional_bus_oe_o,
  input wire logic ack_o,
  input wire logic transfer_o,
  input wire logic data_strobe_o,
  input wire logic [1:0] phase_o
);
  logic [1:0] k;
  logic [39:0] tmap;
  logic run;
  logic oe;
  // test-mode image of the inputs, the bus shows it one cycle later
  assign k = {group_select_high_i, group_select_low_i};
  assign tmap = {adc_data_i[10*(4+k)+:10], adc_data_i[10*(12+k)+:10], 10'h0,
    adc_data_i[10*(8+k)+:10]};
  assign run = mode_select_line_i;
  assign oe = bidirectional_bus_oe_o;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  test_bus_map_a: assert property (!$past(rst_i) && !$past(run) |->
    bidirectional_bus_o == $past(tmap)) else $error("test bus map wrong");
  test_drive_a: assert property (!$past(rst_i) && !$past(run) |-> oe)
    else $error("test mode not driving");
  run_master_a: assert property (run && $past(run) && oe |-> phase_o == 2'h3)
    else $error("bus driven outside readout");
  strobe_inside_a: assert property (data_strobe_o |-> transfer_o && oe && $past(bus_ready_i))
    else $error("strobe outside transfer");
  strobe_pulse_a: assert property (data_strobe_o |=> (!data_strobe_o)[*5])
    else $error("strobe faster than tick");
  ack_width_a: assert property ($rose(ack_o) |-> ack_o[*6] ##1 !ack_o)
    else $error("ack width wrong");
  ack_start_a: assert property ($rose(ack_o) |-> $past(phase_o) == 2'h0 && phase_o == 2'h3)
    else $error("ack outside standby");
  drive_gap_a: assert property ($fell(ack_o) && run |-> (!oe)[*8] ##10 !oe ##1 oe)
    else $error("drive gap wrong");
  xfer_rise_a: assert property ($rose(oe) && run |-> (!transfer_o)[*6] ##1 transfer_o)
    else $error("transfer late");
  oe_release_a: assert property ($fell(transfer_o) && run |-> ##6 !oe)
    else $error("bus held after transfer");
  trig_take_a: assert property (phase_o == 2'h0 && trigger_i && run && !config_access_i
    |-> ##[1:25] phase_o == 2'h2) else $error("trigger not taken");
  cfg_take_a: assert property (phase_o == 2'h0 && config_access_i && run && !trigger_i
    |-> ##[1:25] phase_o == 2'h1) else $error("config not entered");
  // main scenarios: words moved, readout pre-empted, test bus driven
  cover property ($rose(data_strobe_o));
  cover property (phase_o == 2'h3 ##1 phase_o == 2'h2);
  cover property ($rose(oe) && !run);
endmodule : opmc_props

bind opmc_top opmc_props u_props (.ref_clk_i, .rst_i, .mode_select_line_i,
  .group_select_low_i, .group_select_high_i, .adc_data_i, .trigger_i, .config_access_i,
  .bus_ready_i, .bidirectional_bus_o, .bidirectional_bus_oe_o, .ack_o, .transfer_o,
  .data_strobe_o, .phase_o);

//--- tb/opmc_rcu.sv
// opmc readout control unit model: issues instructions, collects words
`timescale 1ns/100ps
module opmc_rcu (
  // clock and stall request
  input wire logic clk_i,
  input wire logic stall_i,
  // device answers
  input wire logic ack_i,
  input wire logic strobe_i,
  input wire logic [39:0] bus_i,
  // instruction and flow control
  output opmc_pkg::opmc_cmd_s cmd_o,
  output logic ready_o
);
  import opmc_pkg::*;
  logic [39:0] q[$];
  integer seed = 32'h13f3;
  logic [31:0] r;
  initial cmd_o = '0;
  initial ready_o = 1'b1;
  // a stalled receiver drops ready at random, words are taken on strobe only
  always @(posedge clk_i)
  begin
    r = $random(seed);
    ready_o <= !stall_i || r[0];
    if (strobe_i)
      q.push_back(bus_i);
  end
  // hold until acknowledge; broadcast gets no answer, so hold one tick
  task send(input opmc_cmd_s c);
    cmd_o <= c;
    if (c.broadcast)
      repeat (6) @(posedge clk_i);
    else
      do @(posedge clk_i); while (ack_i !== 1'b1);
    cmd_o <= '0;
  endtask : send
endmodule : opmc_rcu

//--- tb/opmc_top_tb.sv
// opmc bench: test-mode map, run phases, readout, suspend, scan
`timescale 1ns/100ps
module opmc_top_tb;
  import opmc_pkg::*;
  logic ref_clk_i, rst_i, mode_select_line_i, group_select_low_i, group_select_high_i;
  logic trigger_i, config_access_i, pattern_mode_i, bl_wr_i, bus_ready_i, stall;
  logic scan_enable_i, scan_in_i, scan_out_o, bidirectional_bus_oe_o, ack_o;
  logic transfer_o, data_strobe_o;
  logic [159:0] adc_data_i;
  logic [9:0] samples_per_event_count_i, bl_addr_i, bl_data_i;
  logic [15:0] chan_enable_i;
  logic [39:0] bidirectional_bus_o;
  logic [1:0] phase_o;
  opmc_cmd_s cmd_i;
  logic [9:0] pat[4];
  logic [39:0] e[$];
  integer fails = 0, checks = 0, seed = 32'h13f3, n;
  opmc_top uut (.ref_clk_i, .rst_i, .mode_select_line_i, .group_select_low_i,
    .group_select_high_i, .adc_data_i, .trigger_i, .config_access_i,
    .samples_per_event_count_i, .chan_enable_i, .cmd_i, .pattern_mode_i, .bl_wr_i,
    .bl_addr_i, .bl_data_i, .bus_ready_i, .bidirectional_bus_o, .bidirectional_bus_oe_o,
    .ack_o, .transfer_o, .data_strobe_o, .phase_o, .scan_enable_i, .scan_in_i, .scan_out_o);
  opmc_rcu rcu (.clk_i(ref_clk_i), .stall_i(stall), .ack_i(ack_o), .strobe_i(data_strobe_o),
    .bus_i(bidirectional_bus_o), .cmd_o(cmd_i), .ready_o(bus_ready_i));
  // 250 MHz clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  task chk(input logic [39:0] g, input logic [39:0] x);
    checks++;
    if (g !== x)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk
  task cyc(input int c);
    repeat (c) @(posedge ref_clk_i);
  endtask : cyc
  // zero-time once the phase is there, so it also serves as a bounded wait
  task wph(input logic [1:0] v);
    repeat (40000) if (phase_o !== v) @(posedge ref_clk_i);
  endtask : wph
  function automatic logic [39:0] expw(input int ch, input int i);
    opmc_word_s w;
    w = '0;
    w.chan = ch[3:0];
    w.idx = i[9:0];
    w.sample = pattern_mode_i ? pat[i[1:0]] : adc_data_i[10*ch+:10];
    return w;
  endfunction : expw
  // one event; its length is t sampling ticks of 25 clocks
  task ev(input logic [9:0] s, input int t);
    samples_per_event_count_i <= s;
    trigger_i <= 1'b1;
    wph(2);
    trigger_i <= 1'b0;
    n = 0;
    while (phase_o === 2'h2 && n < 30000)
    begin
      n++;
      cyc(1);
    end
    chk(n >= 25 * t - 25 && n <= 25 * t + 25, 40'h1);
  endtask : ev
  // readout, optionally stalled and pre-empted by a trigger after two words
  task rd(input opmc_cmd_s c, input logic st, sp, input int nw);
    e.delete();
    for (int ch = 0; ch < 16; ch++)
      if (chan_enable_i[ch] && (c.all || c.chan == ch))
        for (int i = 0; i < nw; i++)
          e.push_back(expw(ch, i));
    stall <= st;
    rcu.q.delete();
    rcu.send(c);
    if (sp)
    begin
      repeat (9999) if (rcu.q.size() < 2) cyc(1);
      trigger_i <= 1'b1;
      wph(2);
      trigger_i <= 1'b0;
      chk(bidirectional_bus_oe_o, 40'h0);
    end
    wph(0);
    chk(rcu.q.size(), e.size());
    foreach (e[i]) chk(rcu.q[i], e[i]);
  endtask : rd
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  // cut a hang short
  initial
  begin
    cyc(90000);
    fails++;
    results();
  end
  // main sequence
  initial
  begin
    {mode_select_line_i, group_select_low_i, group_select_high_i, adc_data_i, trigger_i,
      config_access_i, pattern_mode_i, bl_wr_i, scan_enable_i, scan_in_i, stall} = '0;
    {samples_per_event_count_i, bl_addr_i, bl_data_i, chan_enable_i} = '0;
    rst_i = 1'b1;
    cyc(4);
    rst_i <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      adc_data_i <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
      {group_select_high_i, group_select_low_i} <= k[1:0];
      cyc(2);
      chk(bidirectional_bus_o, {adc_data_i[40+10*k+:10], adc_data_i[120+10*k+:10], 10'h0,
        adc_data_i[80+10*k+:10]});
      chk(bidirectional_bus_oe_o, 40'h1);
    end
    mode_select_line_i <= 1'b1;
    cyc(3);
    chk(bidirectional_bus_oe_o, 40'h0);
    chk(phase_o, 40'h0);
    config_access_i <= 1'b1;
    cyc(30);
    trigger_i <= 1'b1;
    cyc(30);
    chk(phase_o, 40'h1);
    {config_access_i, trigger_i} <= 2'b0;
    cyc(30);
    chk(phase_o, 40'h0);
    for (int i = 0; i < 4; i++)
    begin
      pat[i] = 10'($random(seed));
      bl_wr_i <= 1'b1;
      bl_addr_i <= i[9:0];
      bl_data_i <= pat[i];
      cyc(1);
    end
    bl_wr_i <= 1'b0;
    chan_enable_i <= 16'h8421;
    pattern_mode_i <= 1'b1;
    ev(10'h4, 4);
    rd('{1'b1, 1'b1, 1'b0, 4'h0}, 1'b1, 1'b1, 4);
    pattern_mode_i <= 1'b0;
    adc_data_i <= {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    ev(10'h0, 880);
    rd('{1'b1, 1'b0, 1'b0, 4'ha}, 1'b0, 1'b0, 880);
    rcu.send('{1'b1, 1'b0, 1'b1, 4'h5});
    repeat (8)
    begin
      cyc(1);
      chk(ack_o, 40'h0);
    end
    wph(0);
    scan_enable_i <= 1'b1;
    scan_in_i <= 1'b1;
    cyc(1);
    scan_in_i <= 1'b0;
    n = 0;
    while (scan_out_o !== 1'b1 && n < 20000)
    begin
      n++;
      cyc(1);
    end
    chk(n >= 13910 && n <= 13920, 40'h1);
    results();
  end
endmodule : opmc_top_tb
